// *** rpc_pkg.sv ***
/*
  Shared constants and types of the RS-485 port configuration and timing block.
  Assumes a single system clock; every count here is in its own unit.
*/
package rpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and time base
  localparam int CLK_HZ_DEF = 10_000_000;
  localparam int TICK_US = 10_000;
  localparam int TICKS_PER_SEC = 100;
  localparam int TICKS_PER_ERR_UNIT = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Speed codes and bit rates
  localparam int SPEED_W = 3;
  localparam logic [2:0] SPEED_MAX = 3'h4;
  localparam int BAUD_MIN = 2400;
  localparam int BAUD_MAX = 38400;

  function automatic int baudOf(input logic [2:0] code);
    case (code)
      3'h0: baudOf = 2400;
      3'h1: baudOf = 4800;
      3'h2: baudOf = 9600;
      3'h3: baudOf = 19200;
      3'h4: baudOf = 38400;
      default: baudOf = 9600;
    endcase
  endfunction

  function automatic int bitDiv(input int clkHz, input logic [2:0] code);
    bitDiv = clkHz / baudOf(code);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Framing and protocol codes
  localparam logic LEN_8 = 1'b0;
  localparam logic STOP_TWO = 1'b0;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PROTO_RTU = 2'h0;
  localparam logic [1:0] PROTO_LOADER = 2'h1;
  localparam logic [1:0] PROTO_GP = 2'h2;
  localparam logic [1:0] ACT_TRIP = 2'h0;
  localparam logic [1:0] ACT_RUN_ON = 2'h1;
  localparam logic [1:0] ACT_RETRY = 2'h2;
  localparam int LM_FREQ_BIT = 0;
  localparam int LM_RUN_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Timing field limits (seconds, 10 ms units, 0.1 s units)
  localparam int NR_W = 6;
  localparam int LAT_W = 7;
  localparam int ET_W = 10;
  localparam int NR_CNT_W = 13;
  localparam int NORESP_MAX = 60;
  localparam int LATENCY_MAX = 100;
  localparam int ERRTMR_MAX = 600;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_STD_CFG = 8'h00;
  localparam logic [7:0] OFS_STD_TIME = 8'h04;
  localparam logic [7:0] OFS_LINK_MODE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_STATE = 8'h1C;
  localparam int PORT_STRIDE = 8;
  localparam int CFG_SPEED_LSB = 0;
  localparam int CFG_LEN_BIT = 3;
  localparam int CFG_PAR_LSB = 4;
  localparam int CFG_STOP_BIT = 6;
  localparam int CFG_PROTO_LSB = 8;
  localparam int CFG_ACT_LSB = 10;
  localparam int TIME_NR_LSB = 0;
  localparam int TIME_LAT_LSB = 8;
  localparam int TIME_ET_LSB = 16;
  localparam int STATE_PORT_W = 8;
  localparam int ST_W = 4;
  localparam logic [2:0] RST_SPEED = 3'h2;
  localparam logic [1:0] RST_LINK_MODE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {ERR_IDLE, ERR_RUN_ON, ERR_RETRY, ERR_TRIPPED} rpc_err_state_t;

endpackage

// *** rpc_frame_timing.sv ***
/*
  Per-port character framing and bit-period divider.
  Assumes codes are already range-checked by the register file.
*/
`timescale 1ns/1ps
module rpc_frame_timing #(
  parameter int CLK_HZ = rpc_pkg::CLK_HZ_DEF,
  parameter bit LOADER_OK = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [rpc_pkg::SPEED_W-1:0] speedCode,
  input wire logic charLenCode,
  input wire logic [1:0] parityCode,
  input wire logic stopBitsCode,
  input wire logic [1:0] protocolSel,
  output logic bitTick,
  output logic dataBits8,
  output logic parityEn,
  output logic parityOdd,
  output logic stopTwo
);
  import rpc_pkg::*;

  localparam int DIV_W = $clog2(CLK_HZ / BAUD_MIN + 1);

  if (CLK_HZ / BAUD_MAX < 2) begin : g_clk_too_slow
    $error("clock too slow for the fastest bit rate");
  end

  logic [DIV_W-1:0] divCnt_r;
  logic [DIV_W-1:0] divTop;
  logic isRtu;
  logic isLoader;

  assign divTop = DIV_W'(bitDiv(CLK_HZ, speedCode) - 1);
  assign isRtu = (protocolSel == PROTO_RTU);
  assign isLoader = LOADER_OK && (protocolSel == PROTO_LOADER);

  ////////////////////////////////////////////////////////////////////////////
  // Bit period by integer division of the system clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt_r <= '0;
      bitTick <= 1'b0;
    end else if (divCnt_r >= divTop) begin
      divCnt_r <= '0;
      bitTick <= 1'b1;
    end else begin
      divCnt_r <= divCnt_r + 1'b1;
      bitTick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Framing with protocol overrides
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataBits8 <= 1'b1;
      parityEn <= 1'b0;
      parityOdd <= 1'b0;
      stopTwo <= 1'b1;
    end else begin
      dataBits8 <= isRtu || isLoader || (charLenCode == LEN_8);
      if (isLoader) begin
        parityEn <= 1'b1;
        parityOdd <= 1'b0;
        stopTwo <= 1'b0;
      end else begin
        parityEn <= (parityCode == PAR_EVEN) || (parityCode == PAR_ODD);
        parityOdd <= (parityCode == PAR_ODD);
        if (isRtu) begin
          stopTwo <= !((parityCode == PAR_EVEN) || (parityCode == PAR_ODD));
        end else begin
          stopTwo <= (stopBitsCode == STOP_TWO);
        end
      end
    end
  end

endmodule

// *** rpc_port_config_timing.sv ***
/*
  Configuration and timing of the standard and optional RS-485 ports:
  framing, protocol choice, no-response watchdog, reply latency, error
  processing, link-mode routing, AHB-Lite register slave and interrupt.
  Assumes the serial engines report accesses, queries and frame errors as
  one-cycle pulses synchronous to clk.
*/
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module rpc_port_config_timing #(
  parameter int CLK_HZ = rpc_pkg::CLK_HZ_DEF,
  parameter int TICK_CYCLES = rpc_pkg::CLK_HZ_DEF / 1_000_000 * rpc_pkg::TICK_US
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic stdAccessValid,
  input wire logic stdQueryDone,
  input wire logic stdFrameError,
  input wire logic optAccessValid,
  input wire logic optQueryDone,
  input wire logic optFrameError,
  input wire logic driveRunning,
  input wire logic hostFreqFromLink,
  input wire logic hostRunFromLink,
  output logic stdBitTick,
  output logic stdDataBits8,
  output logic stdParityEn,
  output logic stdParityOdd,
  output logic stdStopTwo,
  output logic stdReplyGo,
  output logic stdTrip,
  output logic optBitTick,
  output logic optDataBits8,
  output logic optParityEn,
  output logic optParityOdd,
  output logic optStopTwo,
  output logic optReplyGo,
  output logic optTrip,
  output logic freqFromLink,
  output logic runFromLink,
  output logic irq
);
  import rpc_pkg::*;

  localparam int NPORT = 2;
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [ADDR_W-1:0] cfgOfs(input int p);
    cfgOfs = ADDR_W'(int'(OFS_STD_CFG) + p * PORT_STRIDE);
  endfunction

  function automatic logic [ADDR_W-1:0] timeOfs(input int p);
    timeOfs = ADDR_W'(int'(OFS_STD_TIME) + p * PORT_STRIDE);
  endfunction

  function automatic logic [15:0] sat(input logic [15:0] v, input int mx);
    sat = (int'(v) > mx) ? 16'(mx) : v;
  endfunction

  function automatic logic protoOk(input int p, input logic [1:0] code);
    protoOk = (code == PROTO_RTU) || (code == PROTO_GP) || (p == 0 && code == PROTO_LOADER);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic take;
  logic wrPend_r;
  logic rdPend_r;
  logic addrHit_r;
  logic [ADDR_W-1:0] addr_r;
  logic [31:0] rdMux;
  logic wrHit;
  logic [SPEED_W-1:0] speedR [NPORT];
  logic lenR [NPORT];
  logic [1:0] parR [NPORT];
  logic stopR [NPORT];
  logic [1:0] protoR [NPORT];
  logic [1:0] actR [NPORT];
  logic [NR_W-1:0] nrR [NPORT];
  logic [LAT_W-1:0] latR [NPORT];
  logic [ET_W-1:0] etR [NPORT];
  logic [1:0] linkMode_r;
  logic [ST_W-1:0] status_r;
  logic [ST_W-1:0] mask_r;
  logic [ST_W-1:0] stSet;
  logic [ST_W-1:0] stClr;
  logic [NPORT-1:0] accV;
  logic [NPORT-1:0] qDone;
  logic [NPORT-1:0] frErr;
  logic [NPORT-1:0] tripClr;
  logic [NPORT-1:0] errEvt;
  logic [NPORT-1:0] bitTickP;
  logic [NPORT-1:0] bits8P;
  logic [NPORT-1:0] parEnP;
  logic [NPORT-1:0] parOddP;
  logic [NPORT-1:0] stop2P;
  logic [TICK_W-1:0] tickCnt_r;
  logic baseTick;
  logic [NR_CNT_W-1:0] nrCnt_r [NPORT];
  logic [NPORT-1:0] nrTimeout_r;
  logic [TICK_W-1:0] latPre_r [NPORT];
  logic [LAT_W-1:0] latCnt_r [NPORT];
  logic [NPORT-1:0] latBusy_r;
  logic [NPORT-1:0] replyGo_r;
  rpc_err_state_t errState_r [NPORT];
  logic [3:0] etSub_r [NPORT];
  logic [ET_W-1:0] etCnt_r [NPORT];
  logic [NPORT-1:0] commErr_r;
  logic [NPORT-1:0] tripEvt_r;
  logic linkSourced;

  assign accV = {optAccessValid, stdAccessValid};
  assign qDone = {optQueryDone, stdQueryDone};
  assign frErr = {optFrameError, stdFrameError};

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero wait, reads one wait state
  assign take = hsel && (htrans == HTRANS_NONSEQ) && hready;
  assign hreadyout = !rdPend_r;
  assign hresp = HRESP_OKAY;
  assign wrHit = wrPend_r && addrHit_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      addrHit_r <= 1'b0;
      addr_r <= '0;
    end else begin
      wrPend_r <= take && hwrite;
      rdPend_r <= take && !hwrite;
      if (take) begin
        addr_r <= haddr[ADDR_W-1:0];
        addrHit_r <= (haddr[31:ADDR_W] == '0) && (haddr[1:0] == 2'h0);
      end
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    if (addrHit_r) begin
      for (int p = 0; p < NPORT; p++) begin
        if (addr_r == cfgOfs(p)) begin
          rdMux[CFG_SPEED_LSB +: SPEED_W] = speedR[p];
          rdMux[CFG_LEN_BIT] = lenR[p];
          rdMux[CFG_PAR_LSB +: 2] = parR[p];
          rdMux[CFG_STOP_BIT] = stopR[p];
          rdMux[CFG_PROTO_LSB +: 2] = protoR[p];
          rdMux[CFG_ACT_LSB +: 2] = actR[p];
        end
        if (addr_r == timeOfs(p)) begin
          rdMux[TIME_NR_LSB +: NR_W] = nrR[p];
          rdMux[TIME_LAT_LSB +: LAT_W] = latR[p];
          rdMux[TIME_ET_LSB +: ET_W] = etR[p];
        end
        if (addr_r == OFS_STATE) begin
          rdMux[p * STATE_PORT_W] = (errState_r[p] == ERR_TRIPPED);
          rdMux[p * STATE_PORT_W + 1] = latBusy_r[p];
          rdMux[p * STATE_PORT_W + 2 +: 2] = errState_r[p];
        end
      end
      if (addr_r == OFS_LINK_MODE) begin
        rdMux[1:0] = linkMode_r;
      end
      if (addr_r == OFS_STATUS) begin
        rdMux[ST_W-1:0] = status_r;
      end
      if (addr_r == OFS_MASK) begin
        rdMux[ST_W-1:0] = mask_r;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rdPend_r) begin
      hrdata <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port configuration registers, illegal speed, parity and protocol codes leave the old value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NPORT; p++) begin
        speedR[p] <= RST_SPEED;
        lenR[p] <= LEN_8;
        parR[p] <= PAR_NONE;
        stopR[p] <= STOP_TWO;
        protoR[p] <= PROTO_RTU;
        actR[p] <= ACT_TRIP;
        nrR[p] <= '0;
        latR[p] <= '0;
        etR[p] <= '0;
      end
    end else if (wrHit) begin
      for (int p = 0; p < NPORT; p++) begin
        if (addr_r == cfgOfs(p)) begin
          if (hwdata[CFG_SPEED_LSB +: SPEED_W] <= SPEED_MAX) begin
            speedR[p] <= hwdata[CFG_SPEED_LSB +: SPEED_W];
          end
          lenR[p] <= hwdata[CFG_LEN_BIT];
          if (hwdata[CFG_PAR_LSB +: 2] <= PAR_ODD) begin
            parR[p] <= hwdata[CFG_PAR_LSB +: 2];
          end
          stopR[p] <= hwdata[CFG_STOP_BIT];
          if (protoOk(p, hwdata[CFG_PROTO_LSB +: 2])) begin
            protoR[p] <= hwdata[CFG_PROTO_LSB +: 2];
          end
          actR[p] <= hwdata[CFG_ACT_LSB +: 2];
        end
        if (addr_r == timeOfs(p)) begin
          nrR[p] <= NR_W'(sat(16'(hwdata[TIME_NR_LSB +: 8]), NORESP_MAX));
          latR[p] <= LAT_W'(sat(16'(hwdata[TIME_LAT_LSB +: 8]), LATENCY_MAX));
          etR[p] <= ET_W'(sat(hwdata[TIME_ET_LSB +: 16], ERRTMR_MAX));
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link mode, never retained: reset value on every power-up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      linkMode_r <= RST_LINK_MODE;
    end else if (wrHit && addr_r == OFS_LINK_MODE) begin
      linkMode_r <= hwdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      freqFromLink <= 1'b0;
      runFromLink <= 1'b0;
    end else begin
      freqFromLink <= linkMode_r[LM_FREQ_BIT] || hostFreqFromLink;
      runFromLink <= linkMode_r[LM_RUN_BIT] || hostRunFromLink;
    end
  end

  assign linkSourced = freqFromLink || runFromLink;

  ////////////////////////////////////////////////////////////////////////////
  // Framing units
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    rpc_frame_timing #(
      .CLK_HZ(CLK_HZ),
      .LOADER_OK(g == 0)
    ) u_frame (
      .clk(clk),
      .arst_n(arst_n),
      .speedCode(speedR[g]),
      .charLenCode(lenR[g]),
      .parityCode(parR[g]),
      .stopBitsCode(stopR[g]),
      .protocolSel(protoR[g]),
      .bitTick(bitTickP[g]),
      .dataBits8(bits8P[g]),
      .parityEn(parEnP[g]),
      .parityOdd(parOddP[g]),
      .stopTwo(stop2P[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // 10 ms base tick shared by watchdog and error timer
  assign baseTick = (tickCnt_r == TICK_W'(TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt_r <= '0;
    end else if (baseTick) begin
      tickCnt_r <= '0;
    end else begin
      tickCnt_r <= tickCnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // No-response watchdog
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NPORT; p++) begin
        nrCnt_r[p] <= '0;
      end
      nrTimeout_r <= '0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        nrTimeout_r[p] <= 1'b0;
        if (nrR[p] == '0 || accV[p]) begin
          nrCnt_r[p] <= '0;
        end else if (baseTick) begin
          if (int'(nrCnt_r[p]) + 1 >= int'(nrR[p]) * TICKS_PER_SEC) begin
            nrCnt_r[p] <= '0;
            nrTimeout_r[p] <= 1'b1;
          end else begin
            nrCnt_r[p] <= nrCnt_r[p] + 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply latency, counted in whole ticks from the end of the query
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NPORT; p++) begin
        latPre_r[p] <= '0;
        latCnt_r[p] <= '0;
      end
      latBusy_r <= '0;
      replyGo_r <= '0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        replyGo_r[p] <= 1'b0;
        if (qDone[p]) begin
          latBusy_r[p] <= 1'b1;
          latPre_r[p] <= '0;
          latCnt_r[p] <= '0;
        end else if (latBusy_r[p]) begin
          if (latCnt_r[p] >= latR[p]) begin
            latBusy_r[p] <= 1'b0;
            replyGo_r[p] <= 1'b1;
          end else if (latPre_r[p] == TICK_W'(TICK_CYCLES - 1)) begin
            latPre_r[p] <= '0;
            latCnt_r[p] <= latCnt_r[p] + 1'b1;
          end else begin
            latPre_r[p] <= latPre_r[p] + 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error processing
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      errEvt[p] = (nrTimeout_r[p] || frErr[p]) && driveRunning && linkSourced;
      tripClr[p] = wrHit && (addr_r == OFS_STATUS) && hwdata[2 * p + 1];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NPORT; p++) begin
        errState_r[p] <= ERR_IDLE;
        etSub_r[p] <= '0;
        etCnt_r[p] <= '0;
      end
      commErr_r <= '0;
      tripEvt_r <= '0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        commErr_r[p] <= errEvt[p];
        tripEvt_r[p] <= 1'b0;
        case (errState_r[p])
          ERR_IDLE: begin
            etSub_r[p] <= '0;
            etCnt_r[p] <= '0;
            if (errEvt[p]) begin
              case (actR[p])
                ACT_TRIP: begin
                  errState_r[p] <= ERR_TRIPPED;
                  tripEvt_r[p] <= 1'b1;
                end
                ACT_RUN_ON: errState_r[p] <= ERR_RUN_ON;
                ACT_RETRY: errState_r[p] <= ERR_RETRY;
                default: errState_r[p] <= ERR_IDLE;
              endcase
            end
          end
          ERR_RUN_ON, ERR_RETRY: begin
            if (errState_r[p] == ERR_RETRY && accV[p]) begin
              errState_r[p] <= ERR_IDLE;
            end else if (etCnt_r[p] >= etR[p]) begin
              errState_r[p] <= ERR_TRIPPED;
              tripEvt_r[p] <= 1'b1;
            end else if (baseTick) begin
              if (etSub_r[p] == 4'(TICKS_PER_ERR_UNIT - 1)) begin
                etSub_r[p] <= '0;
                etCnt_r[p] <= etCnt_r[p] + 1'b1;
              end else begin
                etSub_r[p] <= etSub_r[p] + 1'b1;
              end
            end
          end
          ERR_TRIPPED: begin
            if (tripClr[p]) begin
              errState_r[p] <= ERR_IDLE;
            end
          end
          default: errState_r[p] <= ERR_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over write-one-to-clear
  always_comb begin
    stSet = '0;
    stClr = '0;
    for (int p = 0; p < NPORT; p++) begin
      stSet[2 * p] = commErr_r[p];
      stSet[2 * p + 1] = tripEvt_r[p];
    end
    if (wrHit && addr_r == OFS_STATUS) begin
      stClr = hwdata[ST_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= '0;
      mask_r <= '0;
    end else begin
      status_r <= (status_r & ~stClr) | stSet;
      if (wrHit && addr_r == OFS_MASK) begin
        mask_r <= hwdata[ST_W-1:0];
      end
    end
  end

  assign irq = |(status_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Port outputs
  assign stdBitTick = bitTickP[0];
  assign stdDataBits8 = bits8P[0];
  assign stdParityEn = parEnP[0];
  assign stdParityOdd = parOddP[0];
  assign stdStopTwo = stop2P[0];
  assign stdReplyGo = replyGo_r[0];
  assign stdTrip = (errState_r[0] == ERR_TRIPPED);
  assign optBitTick = bitTickP[1];
  assign optDataBits8 = bits8P[1];
  assign optParityEn = parEnP[1];
  assign optParityOdd = parOddP[1];
  assign optStopTwo = stop2P[1];
  assign optReplyGo = replyGo_r[1];
  assign optTrip = (errState_r[1] == ERR_TRIPPED);

endmodule

// *** rpc_checker.sv ***
/* Checker of rpc_port_config_timing: bus timing, ticks, reply, link mode.
   Assumes one clock and the asynchronous active-low reset. */
`timescale 1ns/1ps
module rpc_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic stdBitTick,
  input wire logic optBitTick,
  input wire logic stdQueryDone,
  input wire logic stdReplyGo,
  input wire logic freqFromLink,
  input wire logic runFromLink
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  logic take;
  assign take = hsel && htrans == 2'h2 && hready;
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_std_tick_gap: assert property (stdBitTick |=> !stdBitTick [*8])
    else $error("std tick too close");
  a_opt_tick_gap: assert property (optBitTick |=> !optBitTick [*8])
    else $error("opt tick too close");
  a_reply_early: assert property (stdQueryDone |=> !stdReplyGo)
    else $error("reply too early");
  a_reply_pulse: assert property (stdReplyGo |=> !stdReplyGo)
    else $error("reply go too long");
  a_link_cleared: assert property ($rose(arst_n) |-> !freqFromLink && !runFromLink)
    else $error("link mode not cleared");
endmodule
bind rpc_port_config_timing rpc_checker chk (.*);

// *** rpc_host_model.sv ***
/* Host model: polls this station at a fixed gap while asked to.
   Assumes the clock and reset of the block. */
`timescale 1ns/1ps
module rpc_host_model #(
  parameter int GAP = 500
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic polling,
  output logic access
);
  int cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      access <= 1'b0;
    end else begin
      cnt <= (cnt == GAP) ? 0 : cnt + 1;
      access <= polling && cnt == GAP;
    end
  end
endmodule

// *** rpc_port_config_timing_tb.sv ***
/* Testbench of rpc_port_config_timing.
   Assumes the package, checker and host model are compiled first. */
`timescale 1ns/1ps
module rpc_port_config_timing_tb;
  import rpc_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, poll = 1'b0;
  logic stdQueryDone = 1'b0, stdFrameError = 1'b0, driveRunning = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic hreadyout, hresp, acc, irq, stdBitTick, stdDataBits8, stdParityEn;
  logic stdParityOdd, stdStopTwo, stdReplyGo, stdTrip, freqFromLink, runFromLink;
  logic optDataBits8, optParityEn, optParityOdd, optStopTwo, optReplyGo;
  logic [1:0] hostLink = 2'h0;
  int nFail = 0, numChecks = 0, seed = 82, c, k = 0;
  always #50 clk = ~clk;
  rpc_port_config_timing #(.TICK_CYCLES(10)) dut (.*, .hready(hreadyout), .hsize(3'h2),
    .stdAccessValid(acc), .optAccessValid(acc), .optQueryDone(stdQueryDone),
    .optFrameError(1'b0), .hostFreqFromLink(hostLink[0]), .hostRunFromLink(hostLink[1]),
    .optBitTick(), .optTrip());
  rpc_host_model #(.GAP(500)) host (.clk(clk), .arst_n(arst_n), .polling(poll), .access(acc));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finishTest();
    if (nFail == 0 && numChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic waitOn(input int n, input int lim);
    if (n >= lim) begin
      nFail++;
      finishTest();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    q = hrdata;
    waitOn(n, 50);
  endtask
  task automatic pulseErr();
    stdFrameError <= 1'b1;
    @(posedge clk);
    stdFrameError <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Expected {8 bits, parity on, odd, two stops}
  function automatic logic [3:0] frm(int len, int par, int stp, int pro);
    if (pro == 1) return 4'b1100;
    if (pro == 0) return {1'b1, par != 0, par == 2, par == 0};
    return {len == 0, par != 0, par == 2, stp == 0};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk({runFromLink, freqFromLink}, 0);
    bus(1'b0, OFS_STD_CFG, 0);
    chk(q, 32'h2);
    for (int p = 0; p < 3; p++)
      for (int r = 0; r < 3; r++)
        for (int l = 0; l < 4; l++) begin
          bus(1'b1, OFS_STD_CFG, 32'hC00 | p << 8 | l[1] << 6 | r << 4 | l[0] << 3);
          repeat (2) @(posedge clk);
          chk({stdDataBits8, stdParityEn, stdParityOdd, stdStopTwo}, frm(l[0], r, l[1], p));
        end
    bus(1'b1, 8'h08, 32'h105);
    bus(1'b0, 8'h08, 0);
    chk(q, 32'h2);
    chk({optDataBits8, optParityEn, optParityOdd, optStopTwo}, frm(0, 0, 0, 0));
    for (int k = 0; k < 3; k++) begin
      c = $unsigned($random(seed)) % 5;
      bus(1'b1, OFS_STD_CFG, 32'hE00 | c);
      for (int t = 0; t < 3; t++) begin
        c = c & 7 | 0;
        q = 0;
        do begin @(posedge clk); q++; end while (stdBitTick !== 1'b1 && q < 5000);
        waitOn(q, 5000);
      end
      chk(q, 10_000_000 / (2400 << c));
    end
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, OFS_LINK_MODE, m);
      repeat (2) @(posedge clk);
      chk({runFromLink, freqFromLink}, m);
    end
    bus(1'b1, OFS_LINK_MODE, 0);
    hostLink <= 2'h2;
    repeat (2) @(posedge clk);
    chk({runFromLink, freqFromLink}, 2);
    hostLink <= 2'h0;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk({runFromLink, freqFromLink}, 0);
    bus(1'b1, OFS_LINK_MODE, 1);
    bus(1'b1, OFS_MASK, 32'h3);
    pulseErr();
    chk(irq, 0);
    driveRunning <= 1'b1;
    pulseErr();
    chk({stdTrip, irq}, 3);
    bus(1'b1, OFS_STATUS, 32'h3);
    repeat (2) @(posedge clk);
    chk({stdTrip, irq}, 0);
    bus(1'b1, OFS_STD_CFG, 32'hE02);
    bus(1'b1, OFS_STD_TIME, 32'h1);
    poll <= 1'b1;
    repeat (2500) @(posedge clk);
    chk(irq, 0);
    poll <= 1'b0;
    c = 0;
    while (irq !== 1'b1 && c < 1200) begin @(posedge clk); c++; end
    chk(c >= 490 && c <= 1100, 1);
    bus(1'b1, OFS_STD_TIME, 32'h200);
    bus(1'b1, OFS_STATUS, 32'hF);
    stdQueryDone <= 1'b1;
    @(posedge clk);
    stdQueryDone <= 1'b0;
    c = 0;
    while (stdReplyGo !== 1'b1 && c < 100) begin
      @(posedge clk);
      c++;
      if (optReplyGo === 1'b1) k = c;
    end
    chk(c >= 20 && c <= 30, 1);
    chk(k, 2);
    finishTest();
  end
endmodule
